//--- design/tdx_fault_edge.sv
/*
  External fault input selection, pin synchronisation and trip edge detection.
  Assumes logic inputs are asynchronous pins and the firmware bit is on clk_i.
*/
`timescale 1ns/10ps
module tdx_fault_edge (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [tdx_pkg::LI_N-1:0] li_i,
  input  wire logic                   fw_bit_i,
  input  wire logic [2:0]             src_i,
  input  wire logic                   active_high_i,
  output logic                        level_o,
  output logic                        trip_o
);

  logic [tdx_pkg::LI_N-1:0] sync1;
  logic [tdx_pkg::LI_N-1:0] sync2;
  logic                     prev;

  wire       is_li = (src_i >= tdx_pkg::SRC_PIN_FIRST) && (src_i <= tdx_pkg::SRC_PIN_LAST);
  wire [2:0] li_idx = 3'(src_i - tdx_pkg::SRC_PIN_FIRST);
  wire       raw = is_li ? sync2[li_idx] : ((src_i == tdx_pkg::SRC_FW) & fw_bit_i);
  // Active low inverts so that a falling pin edge reads as a rising fault edge
  wire       lvl = is_li ? (active_high_i ? raw : ~raw) : raw; // R10 R11 R12
  wire       next_trip = (src_i != tdx_pkg::SRC_NONE) & lvl & ~prev; // R09 R11 R12

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1   <= '0;
      sync2   <= '0;
      prev    <= 1'b0;
      level_o <= 1'b0;
      trip_o  <= 1'b0;
    end else begin
      sync1   <= li_i;
      sync2   <= sync1;
      prev    <= lvl;
      level_o <= lvl; // R08
      trip_o  <= next_trip;
    end
  end

endmodule : tdx_fault_edge

//--- design/tdx_thermal_stop.sv
/*
  Thermal deferred stop and external fault protection with a Wishbone register file.
  Assumes thermal states arrive as percent on clk_i, running_i comes from drive control,
  and logic inputs are asynchronous pins.
  // Functional notes
  // [R01] Threshold reached while running: lock at next stop
  // [R02] Release lock at threshold minus twenty percent
  // [R03] Enable off hides thresholds; on gives freewheel
  // [R04] Drive threshold 0 to 118, default 100
  // [R05] Motor 1 threshold 0 to 118, default 100
  // [R06] Motor 2 threshold 0 to 118, default 100
  // [R07] Motor 3 threshold 0 to 118, default 100
  // [R08] Source bit one means external fault
  // [R09] Fault source none, logic input, or firmware
  // [R10] Polarity only for logic input, default high
  // [R11] Active low trips on falling edge
  // [R12] Active high trips on rising edge
  // [R13] Fault applies configurable stop, default freewheel
  // [R14] Reached when state at or above threshold
*/
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
module tdx_thermal_stop (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire tdx_pkg::tdx_wb_req_t        wb_req_i,
  output logic [31:0]                      wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic [tdx_pkg::PCT_W-1:0]   drive_therm_i,
  input  wire logic [tdx_pkg::PCT_W-1:0]   motor_therm_i,
  input  wire logic [1:0]                  motor_sel_i,
  input  wire logic                        running_i,
  input  wire logic [tdx_pkg::LI_N-1:0]    li_i,
  input  wire logic                        fw_fault_bit_i,
  output logic                             restart_lock_o,
  output logic                             freewheel_req_o,
  output logic                             ext_stop_req_o,
  output tdx_pkg::tdx_resp_t               ext_stop_type_o,
  output logic                             irq_o
);

  // Threshold reached test
  function automatic logic reached(input logic [tdx_pkg::PCT_W-1:0] st,
                                   input logic [tdx_pkg::PCT_W-1:0] thr);
    reached = (st >= thr); // R14
  endfunction : reached

  // Level at which the lock may be released
  function automatic logic [tdx_pkg::PCT_W-1:0] release_lvl(input logic [tdx_pkg::PCT_W-1:0] thr);
    if (thr >= tdx_pkg::RELEASE_MARGIN) begin
      release_lvl = thr - tdx_pkg::RELEASE_MARGIN; // R02
    end else begin
      release_lvl = '0;
    end
  endfunction : release_lvl

  // Written threshold clamped to the legal range
  function automatic logic [tdx_pkg::PCT_W-1:0] clamp_thr(input logic [7:0] v);
    clamp_thr = (v > tdx_pkg::THR_MAX) ? tdx_pkg::THR_MAX : v; // R04 R05 R06 R07
  endfunction : clamp_thr

  tdx_pkg::tdx_state_t          state;
  tdx_pkg::tdx_state_t          next_state;
  logic                         therm_en;
  logic                         ext_pol;
  logic [2:0]                   ext_src;
  tdx_pkg::tdx_resp_t           ext_resp;
  logic [tdx_pkg::PCT_W-1:0]    thr_drv;
  logic [tdx_pkg::PCT_W-1:0]    thr_mot [0:2];
  logic [tdx_pkg::EV_N-1:0]     status;
  logic [tdx_pkg::EV_N-1:0]     mask;
  logic                         ext_level;
  logic                         ext_trip;

  // Bus decode
  wire        bus_req   = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  wire        bus_wr    = bus_req & wb_req_i.we;
  wire [7:0]  adr       = wb_req_i.adr;
  wire [31:0] wdat      = wb_req_i.dat;
  wire        wr_b0     = bus_wr & wb_req_i.sel[0];
  wire        wr_b1     = bus_wr & wb_req_i.sel[1];
  wire        hit_ctrl  = (adr == tdx_pkg::ADR_CTRL);
  wire        hit_drv   = (adr == tdx_pkg::ADR_THR_DRV);
  wire        hit_m1    = (adr == tdx_pkg::ADR_THR_M1);
  wire        hit_m2    = (adr == tdx_pkg::ADR_THR_M2);
  wire        hit_m3    = (adr == tdx_pkg::ADR_THR_M3);
  wire        hit_stat  = (adr == tdx_pkg::ADR_STATUS);
  wire        hit_mask  = (adr == tdx_pkg::ADR_MASK);
  wire        hit_state = (adr == tdx_pkg::ADR_STATE);

  // Thresholds are only reachable while the function is enabled
  wire        thr_wr_ok = wr_b0 & therm_en; // R03

  // Polarity can only be changed while a logic input is assigned
  wire [2:0]  new_src   = wdat[tdx_pkg::CTRL_SRC_LSB +: 3];
  wire        src_is_li = (ext_src >= tdx_pkg::SRC_PIN_FIRST) && (ext_src <= tdx_pkg::SRC_PIN_LAST);
  wire        pol_wr_ok = wr_b0 & hit_ctrl & src_is_li; // R10

  // Thermal evaluation against the active motor's threshold
  wire [1:0]  m_idx     = (motor_sel_i > 2'h2) ? 2'h0 : motor_sel_i;
  wire [tdx_pkg::PCT_W-1:0] thr_m_act = thr_mot[m_idx];
  wire        hot       = reached(drive_therm_i, thr_drv) | reached(motor_therm_i, thr_m_act); // R14
  wire        cooled    = (drive_therm_i <= release_lvl(thr_drv)) &&
                          (motor_therm_i <= release_lvl(thr_m_act)); // R02

  // Deferred stop state machine
  always_comb begin
    next_state = state;
    unique case (state)
      tdx_pkg::ST_IDLE: begin
        if (therm_en && hot) begin
          next_state = running_i ? tdx_pkg::ST_PEND : tdx_pkg::ST_LOCK; // R01
        end
      end
      tdx_pkg::ST_PEND: begin
        if (!running_i) begin
          next_state = tdx_pkg::ST_LOCK; // R01
        end
      end
      tdx_pkg::ST_LOCK: begin
        if (cooled) begin
          next_state = tdx_pkg::ST_IDLE; // R02
        end
      end
      default: next_state = tdx_pkg::ST_IDLE;
    endcase
    if (!therm_en) begin
      next_state = tdx_pkg::ST_IDLE; // R03
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= tdx_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // External fault input
  tdx_fault_edge tdx_fault_edge_inst (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .li_i          (li_i),
    .fw_bit_i      (fw_fault_bit_i),
    .src_i         (ext_src),
    .active_high_i (ext_pol),
    .level_o       (ext_level),
    .trip_o        (ext_trip)
  );

  // Events into sticky status; set wins over a write-one clear
  wire [tdx_pkg::EV_N-1:0] ev_set;
  assign ev_set[tdx_pkg::EV_REACH]   = (state == tdx_pkg::ST_IDLE) && (next_state == tdx_pkg::ST_PEND);
  assign ev_set[tdx_pkg::EV_LOCK]    = (state != tdx_pkg::ST_LOCK) && (next_state == tdx_pkg::ST_LOCK);
  assign ev_set[tdx_pkg::EV_RELEASE] = (state == tdx_pkg::ST_LOCK) && (next_state == tdx_pkg::ST_IDLE);
  assign ev_set[tdx_pkg::EV_EXT]     = ext_trip;
  wire [tdx_pkg::EV_N-1:0] ev_clr = (wr_b0 & hit_stat) ? wdat[tdx_pkg::EV_N-1:0] : '0;
  wire [tdx_pkg::EV_N-1:0] next_status = (status & ~ev_clr) | ev_set;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= '0;
      mask   <= '0;
    end else begin
      status <= next_status;
      if (wr_b0 && hit_mask) begin
        mask <= wdat[tdx_pkg::EV_N-1:0];
      end
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      therm_en <= 1'b0;
      ext_pol  <= tdx_pkg::POL_DEF; // R10
      ext_src  <= tdx_pkg::SRC_NONE; // R09
      ext_resp <= tdx_pkg::RESP_FREEWHEEL; // R13
    end else begin
      if (wr_b0 && hit_ctrl) begin
        therm_en <= wdat[tdx_pkg::CTRL_EN_BIT]; // R03
        ext_src  <= new_src; // R09
      end
      if (pol_wr_ok) begin
        ext_pol <= wdat[tdx_pkg::CTRL_POL_BIT];
      end
      if (wr_b1 && hit_ctrl) begin
        ext_resp <= tdx_pkg::tdx_resp_t'(wdat[tdx_pkg::CTRL_RESP_LSB +: 3]); // R13
      end
    end
  end

  // Threshold registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_drv    <= tdx_pkg::THR_DEF; // R04
      thr_mot[0] <= tdx_pkg::THR_DEF; // R05
      thr_mot[1] <= tdx_pkg::THR_DEF; // R06
      thr_mot[2] <= tdx_pkg::THR_DEF; // R07
    end else if (thr_wr_ok) begin
      if (hit_drv) begin
        thr_drv <= clamp_thr(wdat[7:0]); // R04
      end
      if (hit_m1) begin
        thr_mot[0] <= clamp_thr(wdat[7:0]); // R05
      end
      if (hit_m2) begin
        thr_mot[1] <= clamp_thr(wdat[7:0]); // R06
      end
      if (hit_m3) begin
        thr_mot[2] <= clamp_thr(wdat[7:0]); // R07
      end
    end
  end

  // Read mux; hidden thresholds and unmapped offsets read zero
  wire [31:0] rd_ctrl  = {21'h0, ext_resp, 3'h0, ext_src, (src_is_li & ext_pol), therm_en};
  wire [31:0] rd_state = {27'h0, ext_level, 1'b0, state};
  wire [7:0]  rd_thr   = !therm_en ? 8'h00 :
                         hit_drv ? thr_drv :
                         hit_m1  ? thr_mot[0] :
                         hit_m2  ? thr_mot[1] :
                         hit_m3  ? thr_mot[2] : 8'h00; // R03
  wire [31:0] rd_data  = hit_ctrl  ? rd_ctrl :
                         hit_stat  ? {28'h0, status} :
                         hit_mask  ? {28'h0, mask} :
                         hit_state ? rd_state : {24'h0, rd_thr};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_req_i.we) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // Outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restart_lock_o  <= 1'b0;
      freewheel_req_o <= 1'b0;
      ext_stop_req_o  <= 1'b0;
      ext_stop_type_o <= tdx_pkg::RESP_FREEWHEEL;
      irq_o           <= 1'b0;
    end else begin
      restart_lock_o  <= (next_state == tdx_pkg::ST_LOCK); // R01
      freewheel_req_o <= (next_state == tdx_pkg::ST_LOCK) & ~running_i; // R03
      ext_stop_req_o  <= next_status[tdx_pkg::EV_EXT] & (ext_resp != tdx_pkg::RESP_IGNORE); // R13
      ext_stop_type_o <= ext_resp; // R13
      irq_o           <= |(next_status & mask);
    end
  end

  // Checks
  chk_ack_single_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  chk_pend_holds_run: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    (state == tdx_pkg::ST_PEND) && running_i && therm_en |=> (state == tdx_pkg::ST_PEND) && !restart_lock_o)
    else $error("deferred stop locked while still running");

  chk_lock_at_stop: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    (state == tdx_pkg::ST_PEND) && !running_i && therm_en |=> restart_lock_o)
    else $error("no lock after the stop");

  chk_no_early_release: assert property (@(posedge clk_i) disable iff (rst_i) // R02
    (state == tdx_pkg::ST_LOCK) && therm_en &&
    (drive_therm_i > release_lvl(thr_drv)) |=> (state == tdx_pkg::ST_LOCK))
    else $error("lock released above release level");

  chk_release_cool: assert property (@(posedge clk_i) disable iff (rst_i) // R02
    (state == tdx_pkg::ST_LOCK) && cooled |=> (state == tdx_pkg::ST_IDLE) && !restart_lock_o)
    else $error("lock kept after cooling");

  chk_off_inactive: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    !therm_en |=> (state == tdx_pkg::ST_IDLE))
    else $error("thermal stop active while disabled");

  chk_thr_reset: assert property (@(posedge clk_i) // R04
    rst_i |=> (thr_drv == tdx_pkg::THR_DEF) && (thr_mot[0] == tdx_pkg::THR_DEF) &&
              (thr_mot[1] == tdx_pkg::THR_DEF) && (thr_mot[2] == tdx_pkg::THR_DEF))
    else $error("threshold reset value wrong");

  chk_thr_range: assert property (@(posedge clk_i) disable iff (rst_i) // R05
    (thr_drv <= tdx_pkg::THR_MAX) && (thr_mot[0] <= tdx_pkg::THR_MAX) &&
    (thr_mot[1] <= tdx_pkg::THR_MAX) && (thr_mot[2] <= tdx_pkg::THR_MAX))
    else $error("threshold beyond 118 percent");

  chk_none_no_trip: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    (ext_src == tdx_pkg::SRC_NONE) [*3] |-> !ext_trip)
    else $error("external fault with no source");

  chk_ext_trip_req: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    ext_trip && (ext_resp != tdx_pkg::RESP_IGNORE) |=> ext_stop_req_o && status[tdx_pkg::EV_EXT])
    else $error("external fault gave no stop request");

  chk_reach_event: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    (state == tdx_pkg::ST_IDLE) && therm_en && running_i &&
    (drive_therm_i >= thr_drv) |=> (state == tdx_pkg::ST_PEND))
    else $error("threshold reached but not armed");

  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> ((status & $past(mask)) != '0))
    else $error("interrupt without unmasked status");

  chk_lock_is_state: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    restart_lock_o |-> (state == tdx_pkg::ST_LOCK))
    else $error("restart lock outside the locked state");

  chk_freewheel_stopped: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    freewheel_req_o |-> restart_lock_o && !$past(running_i))
    else $error("freewheel request while running or unlocked");

  chk_hidden_thr_kept: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    wr_b0 && !therm_en |=> $stable(thr_drv) && $stable(thr_mot[0]) && $stable(thr_mot[1]) && $stable(thr_mot[2]))
    else $error("threshold written while the function is off");

  chk_clamp_write: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    thr_wr_ok && hit_drv && (wdat[7:0] > tdx_pkg::THR_MAX) |=> (thr_drv == tdx_pkg::THR_MAX))
    else $error("threshold write above range not clamped");

  chk_none_level_low: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    (ext_src == tdx_pkg::SRC_NONE) |=> !ext_level)
    else $error("fault level with no source assigned");

  chk_pol_gated: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    wr_b0 && hit_ctrl && !src_is_li |=> $stable(ext_pol))
    else $error("polarity changed without a logic input source");

  chk_trip_on_edge: assert property (@(posedge clk_i) disable iff (rst_i) // R11 R12
    ext_trip |-> ext_level && !$past(ext_level))
    else $error("external fault trip without an edge");

  chk_stop_req_cause: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    ext_stop_req_o |-> status[tdx_pkg::EV_EXT] && ($past(ext_resp) != tdx_pkg::RESP_IGNORE))
    else $error("stop request without a pending external fault");

  chk_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    status[tdx_pkg::EV_EXT] && !(wr_b0 && hit_stat && wdat[tdx_pkg::EV_EXT]) |=> status[tdx_pkg::EV_EXT])
    else $error("external fault status lost without a clear");

endmodule : tdx_thermal_stop

//--- shared/tdx_pkg.sv
/*
  Shared constants and types for the thermal deferred stop and external fault block.
  Assumes a 32-bit classic Wishbone master and thermal states given in whole percent.
*/
package tdx_pkg;

  localparam int LI_N  = 6;
  localparam int PCT_W = 8;
  localparam int EV_N  = 4;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_THR_DRV = 8'h04;
  localparam logic [7:0] ADR_THR_M1  = 8'h08;
  localparam logic [7:0] ADR_THR_M2  = 8'h0C;
  localparam logic [7:0] ADR_THR_M3  = 8'h10;
  localparam logic [7:0] ADR_STATUS  = 8'h14;
  localparam logic [7:0] ADR_MASK    = 8'h18;
  localparam logic [7:0] ADR_STATE   = 8'h1C;

  // Control field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_POL_BIT  = 1;
  localparam int CTRL_SRC_LSB  = 2;
  localparam int CTRL_RESP_LSB = 8;

  // Status and mask bit positions
  localparam int EV_REACH   = 0;
  localparam int EV_LOCK    = 1;
  localparam int EV_RELEASE = 2;
  localparam int EV_EXT     = 3;

  // Thresholds in percent
  localparam logic [PCT_W-1:0] THR_MAX        = 8'h76;
  localparam logic [PCT_W-1:0] THR_DEF        = 8'h64;
  localparam logic [PCT_W-1:0] RELEASE_MARGIN = 8'h14;

  // External fault source codes: 1..6 pick a logic input
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_PIN_FIRST = 3'h1;
  localparam logic [2:0] SRC_PIN_LAST  = 3'h6;
  localparam logic [2:0] SRC_FW   = 3'h7;

  localparam logic POL_DEF = 1'b1;

  typedef enum logic [2:0] {
    RESP_IGNORE    = 3'h0,
    RESP_FREEWHEEL = 3'h1,
    RESP_PER_STOP  = 3'h2,
    RESP_FALLBACK  = 3'h3,
    RESP_SPD_MAINT = 3'h4,
    RESP_RAMP      = 3'h5,
    RESP_FAST      = 3'h6,
    RESP_DC_INJ    = 3'h7
  } tdx_resp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PEND = 3'b010,
    ST_LOCK = 3'b100
  } tdx_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tdx_wb_req_t;

endpackage : tdx_pkg

//--- verification/tdx_drive_model.sv
/*
  Drive control model: runs on command, stays stopped while restart is locked.
  Assumes the block's lock and freewheel outputs share clk_i.
*/
`timescale 1ns/10ps
module tdx_drive_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_cmd_i,
  input  wire logic lock_i,
  input  wire logic freewheel_i,
  output logic      running_o
);
  // Stops on command or freewheel, restarts only when not locked
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_cmd_i || freewheel_i) begin
      running_o <= 1'b0;
    end else if (!lock_i) begin
      running_o <= 1'b1;
    end
  end
endmodule : tdx_drive_model

//--- verification/tdx_thermal_stop_bench.sv
/*
  Self-checking bench for the thermal deferred stop block.
  Assumes a classic Wishbone master and the drive control model beside it.
*/
`timescale 1ns/10ps
module tdx_thermal_stop_bench;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  tdx_pkg::tdx_wb_req_t  wb_req = '0;
  logic [31:0]           wb_dat;
  logic                  wb_ack;
  logic [7:0]            drive_therm = 8'h00;
  logic [7:0]            motor_therm = 8'h00;
  logic [1:0]            motor_sel = 2'h0;
  logic                  run_cmd = 1'b0;
  logic                  running;
  logic [5:0]            li = 6'h00;
  logic                  fw_bit = 1'b0;
  logic                  restart_lock;
  logic                  freewheel_req;
  logic                  ext_stop_req;
  logic                  irq;
  tdx_pkg::tdx_resp_t    ext_stop_type;
  int                    mismatches = 0;
  int                    checks = 0;

  always #50 clk_i = ~clk_i;

  tdx_thermal_stop tdx_thermal_stop_inst (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .wb_req_i       (wb_req),
    .wb_dat_o       (wb_dat),
    .wb_ack_o       (wb_ack),
    .drive_therm_i  (drive_therm),
    .motor_therm_i  (motor_therm),
    .motor_sel_i    (motor_sel),
    .running_i      (running),
    .li_i           (li),
    .fw_fault_bit_i (fw_bit),
    .restart_lock_o (restart_lock),
    .freewheel_req_o(freewheel_req),
    .ext_stop_req_o (ext_stop_req),
    .ext_stop_type_o(ext_stop_type),
    .irq_o          (irq)
  );

  tdx_drive_model tdx_drive_model_inst (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_cmd_i  (run_cmd),
    .lock_i     (restart_lock),
    .freewheel_i(freewheel_req),
    .running_o  (running)
  );

  task automatic wrap_up();
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // One classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, wb_ack, 1'b1);
    end
    q = wb_dat;
    wb_req <= '0;
    @(posedge clk_i);
  endtask : wb_cycle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd

  task automatic test_reset();
    check(32'(ext_stop_type), 32'h1);
    rd(tdx_pkg::ADR_CTRL, 32'h100);
    rd(tdx_pkg::ADR_THR_DRV, 32'h0);
    wr(tdx_pkg::ADR_CTRL, 32'h101);
    rd(tdx_pkg::ADR_THR_DRV, 32'h64);
    rd(tdx_pkg::ADR_THR_M1, 32'h64);
    rd(tdx_pkg::ADR_THR_M2, 32'h64);
    rd(tdx_pkg::ADR_THR_M3, 32'h64);
    wr(tdx_pkg::ADR_THR_DRV, 32'hFF);
    rd(tdx_pkg::ADR_THR_DRV, 32'h76);
    rd(8'h20, 32'h0);
    rd(tdx_pkg::ADR_STATE, 32'h1);
  endtask : test_reset

  task automatic test_deferred();
    wr(tdx_pkg::ADR_THR_DRV, 32'h50);
    wr(tdx_pkg::ADR_MASK, 32'h2);
    run_cmd <= 1'b1;
    tick(3);
    drive_therm <= 8'h50;
    tick(4);
    check(32'(restart_lock), 32'h0);
    rd(tdx_pkg::ADR_STATE, 32'h2);
    rd(tdx_pkg::ADR_STATUS, 32'h1);
    run_cmd <= 1'b0;
    tick(5);
    check(32'(restart_lock), 32'h1);
    check(32'(freewheel_req), 32'h1);
    rd(tdx_pkg::ADR_STATE, 32'h4);
    check(32'(irq), 32'h1);
    run_cmd <= 1'b1;
    wr(tdx_pkg::ADR_MASK, 32'h0);
    check(32'(irq), 32'h0);
    wr(tdx_pkg::ADR_MASK, 32'h2);
    check(32'(irq), 32'h1);
    drive_therm <= 8'h3D;
    tick(5);
    check(32'(restart_lock), 32'h1);
    drive_therm <= 8'h3C;
    tick(5);
    check(32'(restart_lock), 32'h0);
    run_cmd <= 1'b0;
    rd(tdx_pkg::ADR_STATUS, 32'h7);
    wr(tdx_pkg::ADR_STATUS, 32'h2);
    check(32'(irq), 32'h0);
    rd(tdx_pkg::ADR_STATUS, 32'h5);
  endtask : test_deferred

  task automatic test_motors();
    logic [7:0] thr;
    drive_therm <= 8'h00;
    wr(tdx_pkg::ADR_THR_M1, 32'h1E);
    wr(tdx_pkg::ADR_THR_M2, 32'h28);
    wr(tdx_pkg::ADR_THR_M3, 32'h32);
    for (int m = 0; m < 3; m++) begin
      thr = 8'h1E + 8'(m * 10);
      motor_sel <= 2'(m);
      motor_therm <= thr - 8'h01;
      tick(5);
      check(32'(restart_lock), 32'h0);
      motor_therm <= thr;
      tick(5);
      check(32'(restart_lock), 32'h1);
      motor_therm <= thr - 8'h14;
      tick(5);
      check(32'(restart_lock), 32'h0);
    end
    motor_sel <= 2'h3;
    motor_therm <= 8'h1E;
    tick(5);
    check(32'(restart_lock), 32'h1);
    motor_therm <= 8'h0A;
    tick(5);
    check(32'(restart_lock), 32'h0);
    wr(tdx_pkg::ADR_STATUS, 32'hF);
  endtask : test_motors

  task automatic test_ext();
    wr(tdx_pkg::ADR_CTRL, 32'h107);
    tick(6);
    wr(tdx_pkg::ADR_STATUS, 32'hF);
    li[0] <= 1'b1;
    tick(6);
    rd(tdx_pkg::ADR_STATUS, 32'h8);
    check(32'(ext_stop_req), 32'h1);
    rd(tdx_pkg::ADR_STATE, 32'h11);
    wr(tdx_pkg::ADR_STATUS, 32'h8);
    check(32'(ext_stop_req), 32'h0);
    li[0] <= 1'b0;
    tick(6);
    rd(tdx_pkg::ADR_STATUS, 32'h0);
    wr(tdx_pkg::ADR_CTRL, 32'h105);
    li[0] <= 1'b1;
    tick(6);
    wr(tdx_pkg::ADR_STATUS, 32'h8);
    li[0] <= 1'b0;
    tick(6);
    rd(tdx_pkg::ADR_STATUS, 32'h8);
    wr(tdx_pkg::ADR_STATUS, 32'h8);
    li[0] <= 1'b1;
    tick(6);
    rd(tdx_pkg::ADR_STATUS, 32'h0);
    rd(tdx_pkg::ADR_CTRL, 32'h105);
    wr(tdx_pkg::ADR_CTRL, 32'h103);
    rd(tdx_pkg::ADR_CTRL, 32'h101);
    li[0] <= 1'b0;
    tick(6);
    li[0] <= 1'b1;
    tick(6);
    rd(tdx_pkg::ADR_STATUS, 32'h0);
    wr(tdx_pkg::ADR_CTRL, 32'h11D);
    tick(6);
    wr(tdx_pkg::ADR_STATUS, 32'h8);
    fw_bit <= 1'b1;
    tick(6);
    rd(tdx_pkg::ADR_STATUS, 32'h8);
  endtask : test_ext

  task automatic test_resp();
    for (int r = 0; r < 8; r++) begin
      wr(tdx_pkg::ADR_CTRL, {21'h0, 3'(r), 8'h1D});
      check(32'(ext_stop_type), 32'(r));
      check(32'(ext_stop_req), 32'(r != 0));
    end
  endtask : test_resp

  initial begin
    tick(4);
    rst_i <= 1'b0;
    tick(1);
    test_reset();
    test_deferred();
    test_motors();
    test_ext();
    test_resp();
    wrap_up();
  end

  initial begin
    tick(5000);
    mismatches++;
    wrap_up();
  end
endmodule : tdx_thermal_stop_bench
